//--- design/reset_seq_pkg.sv
package reset_seq_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 20;
  localparam int POWERUP_DELAY_TIMER_COUNTS = 2048;
  localparam int POWERUP_DELAY_TIMER_NOMINAL_US = 65600;
  localparam int OST_COUNTS = 1024;
  localparam int PLL_LOCK_DELAY_NS = 2000000;
  localparam int PLL_LOCK_CYCLES_DEF = PLL_LOCK_DELAY_NS / CLK_PERIOD_NS;
  localparam int BROWNOUT_MIN_DURATION_NS = 1000;
  localparam int BROWNOUT_FILTER_CYCLES_DEF =
    (BROWNOUT_MIN_DURATION_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MASTER_CLEAR_N_FILTER_NS = 200;
  localparam int MASTER_CLEAR_N_FILTER_CYCLES_DEF = (MASTER_CLEAR_N_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DELAY_CNT_W = 17;

  // ----------------------------------------------------------------
  // Brownout enable selections
  // ----------------------------------------------------------------
  localparam logic [1:0] BOR_SEL_OFF = 2'h0;
  localparam logic [1:0] BOR_SEL_SOFTWARE = 2'h1;
  localparam logic [1:0] BOR_SEL_NO_SLEEP = 2'h2;
  localparam logic [1:0] BOR_SEL_ALWAYS = 2'h3;

  // ----------------------------------------------------------------
  // Oscillator mode encodings
  // ----------------------------------------------------------------
  localparam logic [2:0] OSC_LOW_POWER_CRYSTAL_MODE = 3'h0;
  localparam logic [2:0] OSC_CRYSTAL_MODE = 3'h1;
  localparam logic [2:0] OSC_HIGH_SPEED_CRYSTAL_MODE = 3'h2;
  localparam logic [2:0] OSC_HIGH_SPEED_PLL_MODE = 3'h3;
  localparam logic [2:0] OSC_RESISTOR_CAPACITOR_MODE = 3'h4;
  localparam logic [2:0] OSC_EXTERNAL_CLOCK_MODE = 3'h5;
  localparam logic [2:0] OSC_INTERNAL_MODE_ONE = 3'h6;

  // ----------------------------------------------------------------
  // Register map (byte offsets) and fields
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CTRL_OFS = 8'h00;
  localparam logic [7:0] REG_FLAGS_OFS = 8'h04;
  localparam logic [7:0] REG_CONFIG_OFS = 8'h08;
  localparam logic [7:0] REG_SEQ_OFS = 8'h0C;
  localparam int CTRL_SW_EN_BIT = 0;
  localparam int FLAGS_POR_BIT = 0;
  localparam int FLAGS_BOR_BIT = 1;
  localparam logic SW_EN_RESET = 1'b1;
  localparam logic FLAG_RESET = 1'b0;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam logic HRESP_OKAY = 1'b0;

  typedef enum logic [2:0] {
    SEQ_POWER_ON,
    SEQ_BROWNOUT,
    SEQ_POWERUP_DELAY,
    SEQ_OSC_STARTUP,
    SEQ_PLL_LOCK,
    SEQ_RUN
  } seq_state_e;

endpackage

//--- design/min_duration_filter.sv
`timescale 1ns/100ps
`default_nettype none
module min_duration_filter #(
  parameter int COUNT = 4
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic raw_active,
  output logic filtered_active
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  localparam int CW = (COUNT > 1) ? $clog2(COUNT) : 1;
  localparam logic [CW-1:0] LAST = CW'(COUNT - 1);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic out;
  } filt_s;

  filt_s cur_ff;
  filt_s nxt_cur;

  if (COUNT < 1) begin : g_bad_count
    $error("min_duration_filter: COUNT must be at least one");
  end

  // Active only after COUNT consecutive active cycles; drops at once, so release is never delayed.
  always_comb begin
    nxt_cur = cur_ff;
    if (!raw_active) begin
      nxt_cur.cnt = '0;
      nxt_cur.out = 1'b0;
    end else if (cur_ff.cnt == LAST) begin
      nxt_cur.out = 1'b1;
    end else begin
      nxt_cur.cnt = cur_ff.cnt + CW'(1);
    end
  end

  // Register the state.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  assign filtered_active = cur_ff.out;

endmodule // min_duration_filter
`default_nettype wire

//--- design/reset_sequencer.sv
// What this block does
// - Selection 00 turns brownout reset fully off; 11 always enables it, 01 and 10 only as below.
// - Enabled brownout held past minimum duration asserts reset until supply recovers.
// - Power-up timer starts after brownout clears; new brownout restarts it.
// - Brownout enable and power-up timer enable are configured independently.
// - Selection 01 lets the software enable bit switch the detector.
// - Other selections ignore the software bit and read it as zero.
// - Threshold comes only from the level select bits, never from software.
// - Brownout flag clears on every brownout and power-on event.
// - Selection 10 disables detection in sleep, re-enables it when awake.
// - Selection 11 keeps brownout detection on in all modes.
// - Power-up timer counts 2048 slow oscillator ticks while holding reset.
// - Power-up timer runs only when its active-low disable bit is zero.
// - Oscillator start-up counts 1024 external oscillator cycles after power-up delay.
// - Start-up count only in crystal modes, on power-on or oscillator-stopping wake.
// - High-speed PLL mode adds a 2 ms lock delay after start-up count.
// - After power-on pulse: power-up timer if enabled, then oscillator start-up.
// - Resistor-capacitor mode without power-up timer has no start-up delay.
// - Delays run from power-on regardless of master clear; release follows the pin.
// - Power-managed wake applies start-up count and PLL lock, ignoring power-up timer.
// - Master clear low, past a short-pulse filter, resets; pin is never driven.
// - Power-on clears the power-on flag; only software sets it again.
`timescale 1ns/100ps
`default_nettype none
module reset_sequencer
  import reset_seq_pkg::*;
#(
  parameter int PLL_LOCK_CYCLES = reset_seq_pkg::PLL_LOCK_CYCLES_DEF,
  parameter int BROWNOUT_FILTER_CYCLES = reset_seq_pkg::BROWNOUT_FILTER_CYCLES_DEF,
  parameter int MASTER_CLEAR_N_FILTER_CYCLES = reset_seq_pkg::MASTER_CLEAR_N_FILTER_CYCLES_DEF
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic power_on_pulse,
  input wire logic supply_below_threshold,
  input wire logic master_clear_n,
  input wire logic [1:0] brownout_enable_select,
  input wire logic [1:0] brownout_level_select,
  input wire logic powerup_delay_disable_n,
  input wire logic [2:0] osc_mode,
  input wire logic sleep_active,
  input wire logic power_managed_exit,
  input wire logic low_freq_osc_tick,
  input wire logic ext_osc_tick,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output logic internal_reset,
  output logic execution_hold,
  output logic brownout_detector_on,
  output logic [1:0] brownout_threshold_select
);

  // ----------------------------------------------------------------
  // Elaboration checks and state
  // ----------------------------------------------------------------
  if (PLL_LOCK_CYCLES < 1 || PLL_LOCK_CYCLES > (1 << DELAY_CNT_W)) begin : g_bad_pll
    $error("reset_sequencer: PLL_LOCK_CYCLES out of range");
  end
  if (POWERUP_DELAY_TIMER_COUNTS > (1 << DELAY_CNT_W) || OST_COUNTS > (1 << DELAY_CNT_W)) begin : g_bad_cnt
    $error("reset_sequencer: delay counter too narrow");
  end

  localparam logic [DELAY_CNT_W-1:0] POWERUP_DELAY_TIMER_LAST = DELAY_CNT_W'(POWERUP_DELAY_TIMER_COUNTS - 1);
  localparam logic [DELAY_CNT_W-1:0] OST_LAST = DELAY_CNT_W'(OST_COUNTS - 1);
  localparam logic [DELAY_CNT_W-1:0] PLL_LAST = DELAY_CNT_W'(PLL_LOCK_CYCLES - 1);

  typedef struct packed {
    seq_state_e state;
    logic [DELAY_CNT_W-1:0] cnt;
    logic osc_pending;
    logic wake;
    logic sw_en;
    logic por_flag;
    logic bor_flag;
    logic [1:0] level;
    logic bus_pend;
    logic [7:0] bus_addr;
    logic [31:0] rdata;
  } core_s;

  core_s cur_ff;
  core_s nxt_cur;

  logic brownout_trip;
  logic master_clear_n_active;
  logic powerup_delay_timer_enabled;
  logic crystal_mode;
  logic pll_mode;
  logic bus_take;
  logic addr_mapped;

  // ----------------------------------------------------------------
  // Detector enable and input filters
  // ----------------------------------------------------------------
  // Enable decode by selection; the software bit only counts in software mode.
  always_comb begin
    case (brownout_enable_select)
      BOR_SEL_OFF: brownout_detector_on = 1'b0;
      BOR_SEL_SOFTWARE: brownout_detector_on = cur_ff.sw_en;
      BOR_SEL_NO_SLEEP: brownout_detector_on = !sleep_active;
      BOR_SEL_ALWAYS: brownout_detector_on = 1'b1;
      default: brownout_detector_on = 1'b0;
    endcase
  end

  // Short dips below threshold are swallowed by the filter.
  min_duration_filter #(
    .COUNT(BROWNOUT_FILTER_CYCLES)
  ) u_bor_filter (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .raw_active(supply_below_threshold && brownout_detector_on),
    .filtered_active(brownout_trip)
  );

  // Master clear is input only; narrow low pulses are ignored.
  min_duration_filter #(
    .COUNT(MASTER_CLEAR_N_FILTER_CYCLES)
  ) u_master_clear_n_filter (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .raw_active(!master_clear_n),
    .filtered_active(master_clear_n_active)
  );

  // Power-up timer enable does not look at the brownout selection at all.
  assign powerup_delay_timer_enabled = !powerup_delay_disable_n;
  assign crystal_mode = (osc_mode == OSC_LOW_POWER_CRYSTAL_MODE) ||
                        (osc_mode == OSC_CRYSTAL_MODE) ||
                        (osc_mode == OSC_HIGH_SPEED_CRYSTAL_MODE) ||
                        (osc_mode == OSC_HIGH_SPEED_PLL_MODE);
  assign pll_mode = (osc_mode == OSC_HIGH_SPEED_PLL_MODE);
  assign bus_take = hsel && htrans[1] && hready && (hsize == HSIZE_WORD);
  assign addr_mapped = (haddr[31:8] == 24'h00_0000);

  // ----------------------------------------------------------------
  // Sequencer, flags and register file
  // ----------------------------------------------------------------
  // Writes land first so a read in the next address phase sees them.
  always_comb begin
    nxt_cur = cur_ff;
    nxt_cur.level = brownout_level_select;
    // Data phase of a write.
    if (cur_ff.bus_pend) begin
      case (cur_ff.bus_addr)
        REG_CTRL_OFS: nxt_cur.sw_en = hwdata[CTRL_SW_EN_BIT];
        REG_FLAGS_OFS: begin
          nxt_cur.por_flag = hwdata[FLAGS_POR_BIT];
          nxt_cur.bor_flag = hwdata[FLAGS_BOR_BIT];
        end
        default: ;
      endcase
    end
    // Delay chain.
    case (cur_ff.state)
      SEQ_POWER_ON: begin
        if (!power_on_pulse) begin
          nxt_cur.cnt = '0;
          if (powerup_delay_timer_enabled) begin
            nxt_cur.state = SEQ_POWERUP_DELAY;
          end else if (crystal_mode) begin
            nxt_cur.state = SEQ_OSC_STARTUP;
            nxt_cur.osc_pending = 1'b0;
          end else begin
            nxt_cur.state = SEQ_RUN;
            nxt_cur.osc_pending = 1'b0;
          end
        end
      end
      SEQ_BROWNOUT: begin
        if (!brownout_trip) begin
          nxt_cur.cnt = '0;
          if (powerup_delay_timer_enabled) begin
            nxt_cur.state = SEQ_POWERUP_DELAY;
          end else if (cur_ff.osc_pending && crystal_mode) begin
            nxt_cur.state = SEQ_OSC_STARTUP;
            nxt_cur.osc_pending = 1'b0;
          end else begin
            nxt_cur.state = SEQ_RUN;
            nxt_cur.osc_pending = 1'b0;
          end
        end
      end
      SEQ_POWERUP_DELAY: begin
        if (low_freq_osc_tick) begin
          if (cur_ff.cnt == POWERUP_DELAY_TIMER_LAST) begin
            nxt_cur.cnt = '0;
            nxt_cur.osc_pending = 1'b0;
            nxt_cur.state = (cur_ff.osc_pending && crystal_mode) ? SEQ_OSC_STARTUP : SEQ_RUN;
          end else begin
            nxt_cur.cnt = cur_ff.cnt + DELAY_CNT_W'(1);
          end
        end
      end
      SEQ_OSC_STARTUP: begin
        if (ext_osc_tick) begin
          if (cur_ff.cnt == OST_LAST) begin
            nxt_cur.cnt = '0;
            nxt_cur.state = pll_mode ? SEQ_PLL_LOCK : SEQ_RUN;
            nxt_cur.wake = pll_mode ? cur_ff.wake : 1'b0;
          end else begin
            nxt_cur.cnt = cur_ff.cnt + DELAY_CNT_W'(1);
          end
        end
      end
      SEQ_PLL_LOCK: begin
        if (cur_ff.cnt == PLL_LAST) begin
          nxt_cur.cnt = '0;
          nxt_cur.state = SEQ_RUN;
          nxt_cur.wake = 1'b0;
        end else begin
          nxt_cur.cnt = cur_ff.cnt + DELAY_CNT_W'(1);
        end
      end
      SEQ_RUN: begin
        if (power_managed_exit && crystal_mode) begin
          nxt_cur.state = SEQ_OSC_STARTUP;
          nxt_cur.cnt = '0;
          nxt_cur.wake = 1'b1;
        end
      end
      default: nxt_cur.state = SEQ_POWER_ON;
    endcase
    // Reset sources override the chain; hardware clears beat software writes.
    if (power_on_pulse) begin
      nxt_cur.state = SEQ_POWER_ON;
      nxt_cur.cnt = '0;
      nxt_cur.osc_pending = 1'b1;
      nxt_cur.wake = 1'b0;
      nxt_cur.sw_en = SW_EN_RESET;
      nxt_cur.por_flag = 1'b0;
      nxt_cur.bor_flag = 1'b0;
    end else if (brownout_trip && cur_ff.state != SEQ_POWER_ON) begin
      nxt_cur.state = SEQ_BROWNOUT;
      nxt_cur.cnt = '0;
      nxt_cur.wake = 1'b0;
      nxt_cur.bor_flag = 1'b0;
    end
    // Address phase: capture write target, register read data.
    nxt_cur.bus_pend = 1'b0;
    if (bus_take) begin
      nxt_cur.bus_pend = hwrite && addr_mapped;
      nxt_cur.bus_addr = haddr[7:0];
      nxt_cur.rdata = 32'h0000_0000;
      if (!hwrite && addr_mapped) begin
        case (haddr[7:0])
          REG_CTRL_OFS: nxt_cur.rdata[CTRL_SW_EN_BIT] =
            nxt_cur.sw_en && (brownout_enable_select == BOR_SEL_SOFTWARE);
          REG_FLAGS_OFS: begin
            nxt_cur.rdata[FLAGS_POR_BIT] = nxt_cur.por_flag;
            nxt_cur.rdata[FLAGS_BOR_BIT] = nxt_cur.bor_flag;
          end
          REG_CONFIG_OFS: nxt_cur.rdata[8:0] = {brownout_detector_on, osc_mode,
            powerup_delay_disable_n, brownout_level_select, brownout_enable_select};
          REG_SEQ_OFS: nxt_cur.rdata[5:0] = {cur_ff.state, cur_ff.wake,
            execution_hold, internal_reset};
          default: ;
        endcase
      end
    end
  end

  // Register the state; sys_rst is treated like a power-on.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      cur_ff <= '0;
      cur_ff.state <= SEQ_POWER_ON;
      cur_ff.osc_pending <= 1'b1;
      cur_ff.sw_en <= SW_EN_RESET;
      cur_ff.por_flag <= FLAG_RESET;
      cur_ff.bor_flag <= FLAG_RESET;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // A wake delay holds execution without counting as a reset.
  assign internal_reset = master_clear_n_active ||
                          (cur_ff.state != SEQ_RUN && !cur_ff.wake);
  assign execution_hold = internal_reset || (cur_ff.state != SEQ_RUN);
  assign brownout_threshold_select = cur_ff.level;
  assign hreadyout = 1'b1;
  assign hresp = HRESP_OKAY;
  assign hrdata = cur_ff.rdata;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  sequence s_por_release;
    cur_ff.state == SEQ_POWER_ON && !power_on_pulse && !brownout_trip;
  endsequence

  a_sel_off_detector: assert property (
    brownout_enable_select == BOR_SEL_OFF |-> !brownout_detector_on)
    else $error("detector on while selection is off");
  a_sel_always_on: assert property (
    brownout_enable_select == BOR_SEL_ALWAYS |-> brownout_detector_on)
    else $error("detector off while selection is always on");
  a_sleep_gates_bor: assert property (brownout_enable_select == BOR_SEL_NO_SLEEP
    |-> brownout_detector_on == !sleep_active)
    else $error("sleep gating of detector wrong");
  a_sw_bit_steers: assert property (brownout_enable_select == BOR_SEL_SOFTWARE
    |-> brownout_detector_on == cur_ff.sw_en)
    else $error("software bit does not steer detector");
  a_sw_bit_masked: assert property (bus_take && !hwrite && haddr == 32'h0000_0000
    && brownout_enable_select != BOR_SEL_SOFTWARE |=> hrdata[0] == 1'b0)
    else $error("software bit reads nonzero outside software mode");
  a_bor_enters: assert property (brownout_trip && !power_on_pulse
    && cur_ff.state != SEQ_POWER_ON |=> cur_ff.state == SEQ_BROWNOUT
    && !cur_ff.bor_flag && internal_reset)
    else $error("brownout did not enter reset");
  a_por_clears_flags: assert property (power_on_pulse
    |=> !cur_ff.por_flag && !cur_ff.bor_flag && internal_reset)
    else $error("power-on did not clear flags");
  a_powerup_delay_timer_first: assert property (s_por_release and powerup_delay_timer_enabled
    |=> cur_ff.state == SEQ_POWERUP_DELAY && cur_ff.cnt == '0)
    else $error("power-up delay not started after power-on");
  a_no_delay_rc: assert property (s_por_release and !powerup_delay_timer_enabled
    && osc_mode == OSC_RESISTOR_CAPACITOR_MODE |=> cur_ff.state == SEQ_RUN)
    else $error("delay applied in resistor-capacitor mode");
  a_powerup_delay_timer_length: assert property (cur_ff.state == SEQ_POWERUP_DELAY && low_freq_osc_tick
    && cur_ff.cnt == POWERUP_DELAY_TIMER_LAST && !power_on_pulse && !brownout_trip
    |=> cur_ff.state != SEQ_POWERUP_DELAY)
    else $error("power-up delay did not end at its last count");
  a_ost_to_pll: assert property (cur_ff.state == SEQ_OSC_STARTUP && ext_osc_tick
    && cur_ff.cnt == OST_LAST && pll_mode && !power_on_pulse && !brownout_trip
    |=> cur_ff.state == SEQ_PLL_LOCK)
    else $error("PLL lock delay did not follow start-up count");
  a_wake_ost: assert property (cur_ff.state == SEQ_RUN && power_managed_exit
    && crystal_mode && !power_on_pulse && !brownout_trip
    |=> cur_ff.state == SEQ_OSC_STARTUP && execution_hold)
    else $error("wake did not start oscillator count");
  a_master_clear_n_holds: assert property (master_clear_n_active |-> internal_reset)
    else $error("master clear not reflected in reset");

endmodule // reset_sequencer
`default_nettype wire

//--- verification/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
// Outputs are compared at the falling edge, where they are settled, then the bench realigns.
`define CHK(a, b) begin @(negedge sys_clk); check(a, b); @(posedge sys_clk); end
module tb_top;
  import reset_seq_pkg::*;
  logic sys_clk, sys_rst, pon, below, master_clear_n_n, powerup_delay_timer_n, sleep, pmx, hsel, hwrite;
  logic [1:0] bsel, lvl, htrans, thr;
  logic [2:0] osc, hsize;
  logic [31:0] haddr, hwdata, hrdata, d;
  logic hreadyout, hresp, ires, hold, det_on, sw;
  int fails, checked, n;
  logic lf_tick = 1'b0;
  logic ex_tick = 1'b0;
  int div = 0;

  // ------------------------------------------------------------
  // Design, with short counts so the run stays brief
  // ------------------------------------------------------------
  reset_sequencer #(.PLL_LOCK_CYCLES(20), .BROWNOUT_FILTER_CYCLES(3),
    .MASTER_CLEAR_N_FILTER_CYCLES(3)) dut (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .power_on_pulse(pon), .supply_below_threshold(below), .master_clear_n(master_clear_n_n),
    .brownout_enable_select(bsel), .brownout_level_select(lvl),
    .powerup_delay_disable_n(powerup_delay_timer_n), .osc_mode(osc), .sleep_active(sleep),
    .power_managed_exit(pmx), .low_freq_osc_tick(lf_tick), .ext_osc_tick(ex_tick),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .internal_reset(ires), .execution_hold(hold),
    .brownout_detector_on(det_on), .brownout_threshold_select(thr));

  // Free-running 50 MHz clock.
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  // Slow-rate enables: slow oscillator every 2nd cycle, external oscillator every 3rd.
  // Distinct rates expose a counter that listens to the wrong tick.
  always @(posedge sys_clk) begin
    div <= (div == 5) ? 0 : div + 1;
    lf_tick <= (div % 2) == 0;
    ex_tick <= (div % 3) == 0;
  end

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task final_report;
    $display("fails=%0d checked=%0d", fails, checked);
    if (fails == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task cyc(input int k);
    repeat (k) @(posedge sys_clk);
  endtask

  // One AHB single transfer; hready is sampled at rising edges, read data at the data-phase edge.
  task bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
           output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    hsize <= HSIZE_WORD;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
    `CHK(hresp, HRESP_OKAY);
  endtask

  task wr(input logic [7:0] a, input logic [31:0] v);
    logic [31:0] x;
    bus(1'b1, a, v, x);
  endtask

  // Counts cycles until the core reset drops.
  task rel(output int k);
    k = 0;
    do begin
      @(negedge sys_clk);
      k++;
    end while (ires !== 1'b0 && k < 20000);
    @(posedge sys_clk);
  endtask

  task powerup(input logic [2:0] m, input logic pn, output int k);
    osc <= m;
    powerup_delay_timer_n <= pn;
    pon <= 1'b1;
    cyc(3);
    pon <= 1'b0;
    rel(k);
  endtask

  // Reference model of the start-up chain length in cycles.
  function automatic int expd(logic [2:0] m, logic pn);
    return (pn ? 0 : 2 * POWERUP_DELAY_TIMER_COUNTS) + (m <= OSC_HIGH_SPEED_PLL_MODE ? 3 * OST_COUNTS : 0) +
      (m == OSC_HIGH_SPEED_PLL_MODE ? 20 : 0);
  endfunction

  // A watchdog ends a hang through the normal closing path.
  initial begin
    #(80000 * 20);
    fails++;
    final_report;
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    {sys_rst, pon, below, sleep, pmx, hsel, hwrite} = 7'h7f;
    {below, sleep, pmx, hsel, hwrite} = 5'h0;
    {master_clear_n_n, powerup_delay_timer_n} = 2'h2;
    bsel = BOR_SEL_SOFTWARE;
    lvl = 2'h2;
    osc = OSC_CRYSTAL_MODE;
    htrans = 2'h0;
    hsize = HSIZE_WORD;
    haddr = 32'h0;
    hwdata = 32'h0;
    fails = 0;
    checked = 0;
    void'($urandom(32'ha5bc));
    cyc(12);
    sys_rst <= 1'b0;
    pon <= 1'b0;
    lvl <= 2'($urandom);
    bus(1'b0, REG_CTRL_OFS, 32'h0, d);
    `CHK(d, 32'h1);
    cyc(2);
    `CHK(thr, lvl);
    wr(REG_FLAGS_OFS, 32'h3);
    bus(1'b0, REG_FLAGS_OFS, 32'h0, d);
    `CHK(d, 32'h3);
    // Every oscillator mode against the model, power-up timer on for even encodings and off for odd ones.
    for (int i = 0; i < 7; i++) begin
      powerup(3'(i), 1'(i % 2), n);
      `CHK(n >= expd(3'(i), 1'(i % 2)) && n <= expd(3'(i), 1'(i % 2)) + 8, 1);
    end
    powerup(OSC_RESISTOR_CAPACITOR_MODE, 1'b1, n);
    `CHK(n <= 8, 1);
    bus(1'b0, REG_FLAGS_OFS, 32'h0, d);
    `CHK(d, 32'h0);
    // Detector state over every selection, sleep level and random software bit.
    for (int i = 0; i < 8; i++) begin
      bsel <= 2'(i);
      sleep <= i[2];
      sw = 1'($urandom);
      wr(REG_CTRL_OFS, {31'h0, sw});
      bus(1'b0, REG_CTRL_OFS, 32'h0, d);
      `CHK(d, {31'h0, sw && i[1:0] == 2'h1});
      `CHK(det_on, i[1:0] != 2'h0 && (i[1:0] != 2'h1 || sw) && (i[1:0] != 2'h2 || !i[2]));
    end
    bsel <= BOR_SEL_ALWAYS;
    sleep <= 1'b0;
    wr(REG_FLAGS_OFS, 32'h3);
    // A dip shorter than the filter is ignored, a long one resets.
    below <= 1'b1;
    cyc(2);
    below <= 1'b0;
    cyc(4);
    `CHK(ires, 1'b0);
    below <= 1'b1;
    cyc(10);
    `CHK(ires, 1'b1);
    bus(1'b0, REG_FLAGS_OFS, 32'h0, d);
    `CHK(d, 32'h1);
    // Power-up timer restarts from zero after a second dip.
    osc <= OSC_RESISTOR_CAPACITOR_MODE;
    powerup_delay_timer_n <= 1'b0;
    below <= 1'b0;
    cyc(500);
    below <= 1'b1;
    cyc(10);
    below <= 1'b0;
    rel(n);
    `CHK(n >= 2 * POWERUP_DELAY_TIMER_COUNTS && n <= 2 * POWERUP_DELAY_TIMER_COUNTS + 8, 1);
    // Master clear held through all delays; release follows the pin at once.
    master_clear_n_n <= 1'b0;
    pon <= 1'b1;
    cyc(3);
    pon <= 1'b0;
    cyc(4400);
    `CHK(ires, 1'b1);
    master_clear_n_n <= 1'b1;
    rel(n);
    `CHK(n <= 8, 1);
    master_clear_n_n <= 1'b0;
    cyc(1);
    master_clear_n_n <= 1'b1;
    cyc(4);
    `CHK(ires, 1'b0);
    // Wake from a power-managed mode in crystal mode holds execution only.
    osc <= OSC_HIGH_SPEED_CRYSTAL_MODE;
    pmx <= 1'b1;
    cyc(1);
    pmx <= 1'b0;
    cyc(2);
    `CHK({hold, ires}, 2'h2);
    n = 4;
    do begin
      @(negedge sys_clk);
      n++;
    end while (hold !== 1'b0 && n < 5000);
    @(posedge sys_clk);
    `CHK(n >= 3 * OST_COUNTS && n <= 3 * OST_COUNTS + 8, 1);
    bus(1'b0, 8'h10, 32'h0, d);
    `CHK(d, 32'h0);
    final_report;
  end
endmodule // tb_top
`default_nettype wire
